// ==== hdl/iocn_regs.vh ====
// Register offsets, field positions and reset values of the port block
`ifndef IOCN_REGS_VH
`define IOCN_REGS_VH

// ==========================================================
// Register byte offsets
`define IOCN_OFF_DIR      6'h00
`define IOCN_OFF_OUT      6'h04
`define IOCN_OFF_PIN      6'h08
`define IOCN_OFF_ANALOG   6'h0c
`define IOCN_OFF_CHGEN    6'h10
`define IOCN_OFF_PULLUP   6'h14
`define IOCN_OFF_PULLDN   6'h18
`define IOCN_OFF_CHGFLAG  6'h1c
`define IOCN_OFF_CAP34SEL 6'h20
`define IOCN_OFF_SER1SEL  6'h24
`define IOCN_OFF_SER2SEL  6'h28

// ==========================================================
// Field positions of the pin select registers
`define IOCN_SEL_LO_MSB   6
`define IOCN_SEL_LO_LSB   0
`define IOCN_SEL_HI_MSB   14
`define IOCN_SEL_HI_LSB   8
`define IOCN_SEL_CODE_GND 7'h00
`define IOCN_SEL_CODE_121 7'h79

// ==========================================================
// Reset values
`define IOCN_RST_DIR      16'hffff
`define IOCN_RST_ANALOG   16'hffff
`define IOCN_RST_ZERO     16'h0000

// ==========================================================
// Bus answer codes
`define IOCN_RESP_OKAY    2'h0
`define IOCN_RESP_SLVERR  2'h2

`endif

// ==== hdl/iocn_remap_sel.v ====
// Remappable input selector: picks one pin by a 7-bit code, registered
`default_nettype none

module iocn_remap_sel (
   input  wire         clk_sys,   // System clock
   input  wire         sys_rst,   // Async reset, active high
   input  wire [6:0]   selCode,   // Pin number select
   input  wire [127:1] rpIn,      // Remappable input pins
   output reg          periphIn   // Routed peripheral input
);

`include "iocn_regs.vh"

   // ==========================================================
   // Selection; code zero grounds the peripheral input
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         periphIn <= 1'b0;
      end else if (selCode == `IOCN_SEL_CODE_GND) begin
         periphIn <= 1'b0;                         // [R9]
      end else begin
         periphIn <= rpIn[selCode];                // Code 7'h79 picks pin 121 [R9]
      end
   end

endmodule // iocn_remap_sel

`default_nettype wire

// ==== hdl/iocn_port.v ====
// Digital port with change detection, weak pulls and input remapping
//
// Overview of operation
// (R1) Software waits one cycle after direction/output write before reading the port.
// (R2) A change on an enabled pin raises the interrupt request.
// (R3) Change detection keeps raising requests while the device sleeps.
// (R4) Every pin can be chosen individually as a change source.
// (R5) One change enable bit per pin; set enables, clear blocks.
// (R6) Separate per-pin pull-up and pull-down enable registers; set turns on.
// (R7) Software keeps pulls off on pins driven as outputs.
// (R8) Serial receiver 1 input comes from pin chosen by select bits 6..0.
// (R9) Code 1111001 selects pin 121; code 0000000 ties input to ground.
// (R10) Unused bits of pin select registers ignore writes, read zero.
// (R11) Software clears analog select for digital use; resets to all ones.
// (R12) Port input read returns zero on analog pins.
// (R13) Sampled input against previous sample; mismatch sets sticky flag, software clears.
`default_nettype none

module iocn_port (
   input  wire         clk_sys,        // System clock, 100 MHz
   input  wire         sys_rst,        // Async reset, active high
   // AXI4-Lite slave
   input  wire [5:0]   s_axi_awaddr,   // Write address
   input  wire         s_axi_awvalid,  // Write address valid
   output reg          s_axi_awready,  // Write address ready
   input  wire [31:0]  s_axi_wdata,    // Write data
   input  wire [3:0]   s_axi_wstrb,    // Write byte strobes
   input  wire         s_axi_wvalid,   // Write data valid
   output reg          s_axi_wready,   // Write data ready
   output reg  [1:0]   s_axi_bresp,    // Write response
   output reg          s_axi_bvalid,   // Write response valid
   input  wire         s_axi_bready,   // Write response ready
   input  wire [5:0]   s_axi_araddr,   // Read address
   input  wire         s_axi_arvalid,  // Read address valid
   output reg          s_axi_arready,  // Read address ready
   output reg  [31:0]  s_axi_rdata,    // Read data
   output reg  [1:0]   s_axi_rresp,    // Read response
   output reg          s_axi_rvalid,   // Read data valid
   input  wire         s_axi_rready,   // Read data ready
   // Port pins
   input  wire [15:0]  padIn,          // Pin input levels
   output reg  [15:0]  padOut,         // Pin output levels
   output reg  [15:0]  padOe,          // Pin output enables, high drives
   output reg  [15:0]  pullUpEn,       // Weak pull-up enables
   output reg  [15:0]  pullDnEn,       // Weak pull-down enables
   output reg          changeIrq,      // Change interrupt request, level
   // Remapping
   input  wire [127:1] rpIn,           // Remappable input pins
   output wire         ser1RxIn,       // Serial receiver 1 input
   output wire         ser2RxIn,       // Serial receiver 2 input
   output wire         cap3In,         // Input capture 3 input
   output wire         cap4In          // Input capture 4 input
);

`include "iocn_regs.vh"

   // ==========================================================
   // Register state
   reg  [15:0] dir_r;          // 1 = input
   reg  [15:0] latch_r;        // Output latch
   reg  [15:0] analog_r;       // 1 = analog pin
   reg  [15:0] chgEn_r;        // Change enables
   reg  [15:0] chgFlag_r;      // Sticky change flags
   reg  [15:0] pinSample_r;    // Sampled pin levels
   reg  [15:0] pinPrev_r;      // Previous sample
   reg  [6:0]  cap3Sel_r;      // Capture 3 pin number
   reg  [6:0]  cap4Sel_r;      // Capture 4 pin number
   reg  [6:0]  ser1Sel_r;      // Serial 1 pin number
   reg  [6:0]  ser2Sel_r;      // Serial 2 pin number
   reg         awGot_r;        // Write address held
   reg         wGot_r;         // Write data held
   reg  [5:0]  awAddr_r;       // Held write address
   reg  [31:0] wData_r;        // Held write data
   reg  [3:0]  wStrb_r;        // Held strobes
   reg         primed_r;       // First sample taken

   wire        wrDo;
   wire [15:0] wrMask;
   wire [15:0] wrVal;
   wire [15:0] pinDigital;
   wire [15:0] changeSeen;
   reg  [15:0] flagClr;
   reg  [31:0] rdWord;
   reg         rdHit;
   reg         wrHit;

   // ==========================================================
   // Byte-lane merge for 16-bit registers
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] mask;
      input [15:0] val;
      begin
         merge16 = (old & ~mask) | (val & mask);
      end
   endfunction

   // Known register offset check, shared by both channels
   function isMapped;
      input [5:0] a;
      begin
         isMapped = (a == `IOCN_OFF_DIR)     || (a == `IOCN_OFF_OUT)     ||
                    (a == `IOCN_OFF_PIN)     || (a == `IOCN_OFF_ANALOG)  ||
                    (a == `IOCN_OFF_CHGEN)   || (a == `IOCN_OFF_PULLUP)  ||
                    (a == `IOCN_OFF_PULLDN)  || (a == `IOCN_OFF_CHGFLAG) ||
                    (a == `IOCN_OFF_CAP34SEL) || (a == `IOCN_OFF_SER1SEL) ||
                    (a == `IOCN_OFF_SER2SEL);
      end
   endfunction

   assign wrDo   = awGot_r & wGot_r & ~s_axi_bvalid;
   assign wrMask = {{8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
   assign wrVal  = wData_r[15:0];

   // ==========================================================
   // Write channel: address and data taken in either order
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `IOCN_RESP_OKAY;
         awGot_r       <= 1'b0;
         wGot_r        <= 1'b0;
         awAddr_r      <= 6'h00;
         wData_r       <= 32'h0000_0000;
         wStrb_r       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awGot_r       <= 1'b1;
            awAddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!awGot_r && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wGot_r       <= 1'b1;
            wData_r      <= s_axi_wdata;
            wStrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!wGot_r && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         // Commit and answer once both halves are in
         if (wrDo) begin
            awGot_r      <= 1'b0;
            wGot_r       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? `IOCN_RESP_OKAY : `IOCN_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Writable offsets; the input value register is read-only
   always @* begin
      wrHit = isMapped(awAddr_r) && (awAddr_r != `IOCN_OFF_PIN);
   end

   // ==========================================================
   // Control registers written by software
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         dir_r     <= `IOCN_RST_DIR;
         latch_r   <= `IOCN_RST_ZERO;
         analog_r  <= `IOCN_RST_ANALOG;           // Pins start analog [R11]
         chgEn_r   <= `IOCN_RST_ZERO;
         pullUpEn  <= `IOCN_RST_ZERO;
         pullDnEn  <= `IOCN_RST_ZERO;
         padOut    <= `IOCN_RST_ZERO;
         padOe     <= `IOCN_RST_ZERO;
         cap3Sel_r <= 7'h00;
         cap4Sel_r <= 7'h00;
         ser1Sel_r <= 7'h00;
         ser2Sel_r <= 7'h00;
      end else begin
         if (wrDo) begin
            case (awAddr_r)
               `IOCN_OFF_DIR:    dir_r    <= merge16(dir_r, wrMask, wrVal);
               `IOCN_OFF_OUT:    latch_r  <= merge16(latch_r, wrMask, wrVal);
               `IOCN_OFF_ANALOG: analog_r <= merge16(analog_r, wrMask, wrVal);
               `IOCN_OFF_CHGEN:  chgEn_r  <= merge16(chgEn_r, wrMask, wrVal);   // [R5]
               `IOCN_OFF_PULLUP: pullUpEn <= merge16(pullUpEn, wrMask, wrVal);  // [R6]
               `IOCN_OFF_PULLDN: pullDnEn <= merge16(pullDnEn, wrMask, wrVal);  // [R6]
               `IOCN_OFF_CAP34SEL: begin
                  // Only the two 7-bit fields exist; other bits dropped [R10]
                  if (wStrb_r[0]) cap3Sel_r <= wData_r[`IOCN_SEL_LO_MSB:`IOCN_SEL_LO_LSB];
                  if (wStrb_r[1]) cap4Sel_r <= wData_r[`IOCN_SEL_HI_MSB:`IOCN_SEL_HI_LSB];
               end
               `IOCN_OFF_SER1SEL: begin
                  if (wStrb_r[0]) ser1Sel_r <= wData_r[`IOCN_SEL_LO_MSB:`IOCN_SEL_LO_LSB]; // [R8] [R10]
               end
               `IOCN_OFF_SER2SEL: begin
                  if (wStrb_r[0]) ser2Sel_r <= wData_r[`IOCN_SEL_LO_MSB:`IOCN_SEL_LO_LSB]; // [R10]
               end
               default: ;
            endcase
         end
         // Pins follow one cycle after the write; a read accepted three cycles after the write sees them [R1]
         padOut <= latch_r;
         padOe  <= ~dir_r;
      end
   end

   // ==========================================================
   // Pin sampling; analog pins read as low
   assign pinDigital = padIn & ~analog_r;                       // [R12]
   assign changeSeen = (pinSample_r ^ pinPrev_r) & chgEn_r & {16{primed_r}}; // [R4] [R13]

   // Software clear mask for the sticky flags, write-one-to-clear
   always @* begin
      flagClr = 16'h0000;
      if (wrDo && (awAddr_r == `IOCN_OFF_CHGFLAG)) begin
         flagClr = wrMask & wrVal;
      end
   end

   // Sampling and sticky flags; a change in the clear cycle is kept.
   // Sampling runs on clk_sys, which must stay alive in sleep for detection.
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pinSample_r <= 16'h0000;
         pinPrev_r   <= 16'h0000;
         primed_r    <= 1'b0;
         chgFlag_r   <= 16'h0000;
         changeIrq   <= 1'b0;
      end else begin
         pinSample_r <= pinDigital;
         pinPrev_r   <= pinSample_r;
         primed_r    <= 1'b1;                                   // Masks only the first cycle, where both samples still hold reset values
         chgFlag_r   <= (chgFlag_r & ~flagClr) | changeSeen;    // [R13] [R3]
         changeIrq   <= |((chgFlag_r & ~flagClr) | changeSeen); // [R2] [R3]
      end
   end

   // ==========================================================
   // Read mux
   always @* begin
      rdWord = 32'h0000_0000;
      rdHit  = isMapped(s_axi_araddr);
      case (s_axi_araddr)
         `IOCN_OFF_DIR:      rdWord[15:0] = dir_r;
         `IOCN_OFF_OUT:      rdWord[15:0] = latch_r;
         `IOCN_OFF_PIN:      rdWord[15:0] = pinSample_r;        // Analog bits zero [R12]
         `IOCN_OFF_ANALOG:   rdWord[15:0] = analog_r;
         `IOCN_OFF_CHGEN:    rdWord[15:0] = chgEn_r;
         `IOCN_OFF_PULLUP:   rdWord[15:0] = pullUpEn;
         `IOCN_OFF_PULLDN:   rdWord[15:0] = pullDnEn;
         `IOCN_OFF_CHGFLAG:  rdWord[15:0] = chgFlag_r;
         `IOCN_OFF_CAP34SEL: rdWord[15:0] = {1'b0, cap4Sel_r, 1'b0, cap3Sel_r}; // [R10]
         `IOCN_OFF_SER1SEL:  rdWord[15:0] = {9'h000, ser1Sel_r}; // [R10]
         `IOCN_OFF_SER2SEL:  rdWord[15:0] = {9'h000, ser2Sel_r}; // [R10]
         default:            rdWord = 32'h0000_0000;
      endcase
   end

   // Read channel: one read in flight, answer one cycle after the address
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `IOCN_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdWord;
            s_axi_rresp   <= rdHit ? `IOCN_RESP_OKAY : `IOCN_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Peripheral input routing
   iocn_remap_sel uSer1 (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .selCode  (ser1Sel_r),   // [R8]
      .rpIn     (rpIn),
      .periphIn (ser1RxIn)
   );

   iocn_remap_sel uSer2 (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .selCode  (ser2Sel_r),
      .rpIn     (rpIn),
      .periphIn (ser2RxIn)
   );

   iocn_remap_sel uCap3 (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .selCode  (cap3Sel_r),
      .rpIn     (rpIn),
      .periphIn (cap3In)
   );

   iocn_remap_sel uCap4 (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .selCode  (cap4Sel_r),
      .rpIn     (rpIn),
      .periphIn (cap4In)
   );

endmodule // iocn_port

`default_nettype wire

// ==== dv/iocn_port_assertions.sv ====
// Concurrent checks on the port block's pins and register bus
`default_nettype none

module iocn_port_assertions (
   input wire logic         clk_sys,       // Clock
   input wire logic         sys_rst,       // Reset
   input wire logic         s_axi_awvalid, // AW valid
   input wire logic         s_axi_awready, // AW ready
   input wire logic         s_axi_wvalid,  // W valid
   input wire logic         s_axi_wready,  // W ready
   input wire logic         s_axi_bvalid,  // B valid
   input wire logic         s_axi_arvalid, // AR valid
   input wire logic         s_axi_arready, // AR ready
   input wire logic [31:0]  s_axi_rdata,   // R data
   input wire logic         s_axi_rvalid,  // R valid
   input wire logic         s_axi_rready,  // R ready
   input wire logic [15:0]  padIn,         // Pin levels
   input wire logic [15:0]  padOe,         // Drive enables
   input wire logic [15:0]  pullUpEn,      // Pull-ups
   input wire logic [15:0]  pullDnEn,      // Pull-downs
   input wire logic         changeIrq,     // Change request
   input wire logic [127:1] rpIn,          // Remap pins
   input wire logic         ser1RxIn       // Serial 1 input
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // ==========================================================
   // Pins and change flags
   AST_PULLUP_WR: assert property ($changed(pullUpEn) |-> $rose(s_axi_bvalid))
      else $error("pull-up enables moved without a write");
   AST_PULLDN_WR: assert property ($changed(pullDnEn) |-> $rose(s_axi_bvalid))
      else $error("pull-down enables moved without a write");
   AST_OE_AFTER_WR: assert property ($changed(padOe) |-> $past(s_axi_bvalid))
      else $error("drive enables moved without a write");
   // Window of four samples covers sampling plus flag latency
   AST_IRQ_CAUSE: assert property ($rose(changeIrq) |->
      ($past(padIn) != $past(padIn, 2)) || ($past(padIn, 2) != $past(padIn, 3))
      || ($past(padIn, 3) != $past(padIn, 4)))
      else $error("change request without a pin change");
   AST_IRQ_STICKY: assert property ($fell(changeIrq) |-> $rose(s_axi_bvalid))
      else $error("change request dropped without a clear");
   AST_SER1_SRC: assert property ($rose(ser1RxIn) |-> $past(|rpIn))
      else $error("serial input rose with all remap pins low");

   // ==========================================================
   // Register bus
   AST_RD_HIGH_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer withdrawn early");
   AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule // iocn_port_assertions

bind iocn_port iocn_port_assertions i_iocn_port_assertions (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .padIn(padIn), .padOe(padOe), .pullUpEn(pullUpEn), .pullDnEn(pullDnEn),
   .changeIrq(changeIrq), .rpIn(rpIn), .ser1RxIn(ser1RxIn));
`default_nettype wire

// ==== dv/iocn_pin_model.sv ====
// Model of the board wiring seen by the port pins
`default_nettype none

module iocn_pin_model (
   input wire logic        clk_sys,  // Clock
   input wire logic [15:0] padOut,   // Device levels
   input wire logic [15:0] padOe,    // Device drives
   input wire logic [15:0] pullUpEn, // Pull-ups on
   input wire logic [15:0] pullDnEn, // Pull-downs on
   input wire logic [15:0] extEn,    // Outside source drives
   input wire logic [15:0] extLvl,   // Outside level
   output logic [15:0]     padIn     // Resolved level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] floatLvl = 16'h5555;

   // Undriven pins wander so a stale level never passes
   always @(posedge clk_sys) begin
      floatLvl <= ~floatLvl;
   end

   // Device drive wins, then outside source, then weak pulls
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         padIn[i] = padOe[i] ? padOut[i] : extEn[i] ? extLvl[i] :
            pullUpEn[i] ? 1'b1 : pullDnEn[i] ? 1'b0 : floatLvl[i];
      end
   end
endmodule // iocn_pin_model
`default_nettype wire

// ==== dv/tb_iocn_port.sv ====
// Self-checking bench of the port block
`include "iocn_regs.vh"
`default_nettype none

module tb_io_port_change_notify_input_remap;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, sys_rst = 1'b1;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] padIn, padOut, padOe, pullUpEn, pullDnEn;
   logic [15:0] extEn = 16'hffff, extLvl = 16'hffa0;
   logic [127:1] rpIn = '0;
   logic changeIrq, ser1RxIn, ser2RxIn, cap3In, cap4In;
   int failures = 0, totalChecks = 0, cycles = 0;

   iocn_port i_iocn_port (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .padIn(padIn),
      .padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn), .pullDnEn(pullDnEn),
      .changeIrq(changeIrq), .rpIn(rpIn), .ser1RxIn(ser1RxIn), .ser2RxIn(ser2RxIn),
      .cap3In(cap3In), .cap4In(cap4In));

   iocn_pin_model i_iocn_pin_model (.clk_sys(clk_sys), .padOut(padOut), .padOe(padOe),
      .pullUpEn(pullUpEn), .pullDnEn(pullDnEn), .extEn(extEn), .extLvl(extLvl),
      .padIn(padIn));

   // ==========================================================
   // Clock, hang guard and common tasks
   always #5 clk_sys = ~clk_sys;

   // A run of under a thousand cycles is expected
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic [1:0] er = 2'h0);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, {16'h0, e});
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rd(`IOCN_OFF_ANALOG, 16'hffff);
      rd(`IOCN_OFF_DIR, 16'hffff);
      rd(`IOCN_OFF_CHGEN, 16'h0000);
      rd(`IOCN_OFF_SER1SEL, 16'h0000);
      rd(6'h2c, 16'h0000, `IOCN_RESP_SLVERR);
      wr(`IOCN_OFF_PIN, 16'h1234, `IOCN_RESP_SLVERR);
      $display("test regs done");
   endtask

   // Outputs on low nibble, analog high byte; pulls stay off here
   task automatic t_pins();
      wr(`IOCN_OFF_ANALOG, 16'hff00);
      wr(`IOCN_OFF_DIR, 16'hfff0);
      wr(`IOCN_OFF_OUT, 16'h0005);
      repeat (2) @(posedge clk_sys);
      chk({16'h0, padOe}, 32'h000f);
      rd(`IOCN_OFF_PIN, 16'h00a5);
      wr(`IOCN_OFF_DIR, 16'hffff);
      wr(`IOCN_OFF_OUT, 16'h0000);
      $display("test pins done");
   endtask

   task automatic t_pulls();
      wr(`IOCN_OFF_ANALOG, 16'h0000);
      extEn <= 16'h0000;
      wr(`IOCN_OFF_PULLUP, 16'h00ff);
      wr(`IOCN_OFF_PULLDN, 16'hff00);
      chk({pullUpEn, pullDnEn}, 32'h00ffff00);
      repeat (2) @(posedge clk_sys);
      rd(`IOCN_OFF_PIN, 16'h00ff);
      rd(`IOCN_OFF_PULLDN, 16'hff00);
      extEn <= 16'hffff;
      wr(`IOCN_OFF_PULLUP, 16'h0000);
      wr(`IOCN_OFF_PULLDN, 16'h0000);
      $display("test pulls done");
   endtask

   // Bus stays idle while waiting, as it would in sleep
   task automatic t_change();
      for (int i = 0; i < 16; i++) begin
         wr(`IOCN_OFF_CHGEN, 16'h1 << i);
         extLvl[(i + 1) % 16] <= ~extLvl[(i + 1) % 16];
         repeat (4) @(posedge clk_sys);
         chk({31'h0, changeIrq}, 32'h0);
         extLvl[i] <= ~extLvl[i];
         repeat (4) @(posedge clk_sys);
         chk({31'h0, changeIrq}, 32'h1);
         rd(`IOCN_OFF_CHGFLAG, 16'h1 << i);
         wr(`IOCN_OFF_CHGFLAG, 16'h1 << i);
         repeat (2) @(posedge clk_sys);
         chk({31'h0, changeIrq}, 32'h0);
      end
      wr(`IOCN_OFF_ANALOG, 16'h0001);
      wr(`IOCN_OFF_CHGEN, 16'h0001);
      extLvl[0] <= ~extLvl[0];
      repeat (4) @(posedge clk_sys);
      chk({31'h0, changeIrq}, 32'h0);
      $display("test change done");
   endtask

   task automatic t_remap();
      wr(`IOCN_OFF_SER1SEL, 16'hffff);
      rd(`IOCN_OFF_SER1SEL, 16'h007f);
      wr(`IOCN_OFF_CAP34SEL, 16'hffff);
      rd(`IOCN_OFF_CAP34SEL, 16'h7f7f);
      wr(`IOCN_OFF_SER2SEL, 16'hffff);
      rd(`IOCN_OFF_SER2SEL, 16'h007f);
      wr(`IOCN_OFF_SER1SEL, {9'h0, `IOCN_SEL_CODE_121});
      rpIn[121] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, ser1RxIn}, 32'h1);
      rpIn[121] <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, ser1RxIn}, 32'h0);
      wr(`IOCN_OFF_SER1SEL, {9'h0, `IOCN_SEL_CODE_GND});
      rpIn <= '1;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, ser1RxIn}, 32'h0);
      wr(`IOCN_OFF_SER2SEL, 16'h0005);
      wr(`IOCN_OFF_CAP34SEL, 16'h0a03);
      rpIn <= 127'h14;
      repeat (3) @(posedge clk_sys);
      chk({29'h0, ser2RxIn, cap3In, cap4In}, 32'h6);
      $display("test remap done");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_regs();
      t_pins();
      t_pulls();
      t_change();
      t_remap();
      complete_run();
   end
endmodule // tb_io_port_change_notify_input_remap
`default_nettype wire
